//--- core/uhrp_pkg.sv
// uhrp_pkg: constants and carrier types for the hid report handler.
// assumes a 125 MHz system clock and byte-wide report streams.
package uhrp_pkg;
  // report framing
  localparam int          REPORT_BYTES   = 64;
  localparam int          IDX_W          = 6;
  localparam logic [7:0]  ID_ACK         = 8'h40;
  localparam logic [7:0]  ID_DATA_MAX    = 8'h3f;
  localparam logic [7:0]  ID_ACKREQ_MAX  = 8'h7f;
  localparam logic [7:0]  ID_CMD_MIN     = 8'h80;
  localparam logic [7:0]  ID_PERSIST_MAX = 8'h8f;
  localparam logic [7:0]  ACK_FLAG       = 8'h40;
  localparam logic [7:0]  OLD_REV_MAX    = 8'h3e;
  localparam logic [15:0] FW_REV_FULL    = 16'h0007;
  // commands
  localparam logic [7:0]  PIN_QUERY_CMD    = 8'h90;
  localparam logic [7:0]  INTERRUPT_RSP    = 8'h95;
  localparam logic [7:0]  ANALOG_QUERY_CMD = 8'h96;
  localparam logic [7:0]  PIN_SEL_BASE     = 8'h10;
  localparam logic [7:0]  PIN_SEL_LAST     = 8'h1a;
  localparam logic [7:0]  PIN_HIGH         = 8'h01;
  localparam logic [7:0]  PIN_LOW          = 8'h00;
  localparam int          NUM_VIO          = 11;
  // power negotiation timing
  localparam longint      CLK_HZ          = 125_000_000;
  localparam longint      GRANT_WAIT_MS   = 3000;
  localparam longint      GRANT_WAIT_CYC  = CLK_HZ / 1000 * GRANT_WAIT_MS;
  localparam longint      DETACH_NS       = 10_000;
  localparam longint      DETACH_CYC      = (DETACH_NS * CLK_HZ + 999_999_999)
                                            / 1_000_000_000;
  localparam logic [9:0]  REDUCED_MA      = 10'h064;

  // one report byte on a stream
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } uhrp_byte_t;

  typedef enum logic [3:0] {
    PWR_FULL   = 4'b0001,
    PWR_DETACH = 4'b0010,
    PWR_LOW    = 4'b0100,
    PWR_OK     = 4'b1000
  } uhrp_pwr_t;

  typedef enum logic [4:0] {
    RX_ID    = 5'b00001,
    RX_BODY  = 5'b00010,
    TX_SEND  = 5'b00100,
    TX_WAIT  = 5'b01000,
    RX_DRAIN = 5'b10000
  } uhrp_rx_t;
endpackage

//--- core/uhrp_power.sv
// uhrp_power: usb current negotiation and power indicator outputs.
// assumes configured/grant/sleep levels come from the usb core, same clock.
`timescale 1ns/1ns
module uhrp_power
  import uhrp_pkg::*;
#(
  parameter longint WAIT_CYC   = GRANT_WAIT_CYC,
  parameter longint DETACH_LEN = DETACH_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_configured,
  input  wire logic       i_power_granted,
  input  wire logic       i_host_sleep,
  input  wire logic [9:0] i_full_ma,
  output logic [9:0]      o_request_ma,
  output logic            o_soft_detach,
  output logic            o_low_power,
  output logic            o_all_systems_go_n
);
  // both counts run in a 32-bit counter, so larger values are refused
  if (WAIT_CYC < 2 || DETACH_LEN < 1
      || WAIT_CYC > 64'h0000_0000_ffff_ffff
      || DETACH_LEN > 64'h0000_0000_ffff_ffff) begin : g_bad_count
    $error("uhrp_power: counts out of range");
  end

  typedef struct packed {
    uhrp_pwr_t   st;
    logic [31:0] cnt;
    logic [9:0]  req;
    logic        detach;
    logic        low;
    logic        go_n;
  } uhrp_pwr_state_t;

  uhrp_pwr_state_t s;
  uhrp_pwr_state_t next_s;

  // negotiation: full first, drop to reduced after the grant timeout
  always_comb begin
    next_s = s;
    unique case (s.st)
      PWR_FULL: begin
        next_s.req = i_full_ma;
        if (i_power_granted) begin
          next_s.st = PWR_OK;
        end else if (s.cnt == 32'(WAIT_CYC - 1)) begin
          next_s.st     = PWR_DETACH;
          next_s.cnt    = '0;
          next_s.detach = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 32'h0000_0001;
        end
      end
      PWR_DETACH: begin
        next_s.req = REDUCED_MA;
        if (s.cnt == 32'(DETACH_LEN - 1)) begin
          next_s.st     = PWR_LOW;
          next_s.detach = 1'b0;
          next_s.low    = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 32'h0000_0001;
        end
      end
      PWR_LOW: next_s.low = 1'b1;
      PWR_OK:  next_s.low = 1'b0;
    endcase
    // load switch only when configured and host awake
    next_s.go_n = ~(i_configured & ~i_host_sleep);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s.st     <= PWR_FULL;
      s.cnt    <= '0;
      s.req    <= '0;
      s.detach <= 1'b0;
      s.low    <= 1'b0;
      s.go_n   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_request_ma       = s.req;
  assign o_soft_detach      = s.detach;
  assign o_low_power        = s.low;
  assign o_all_systems_go_n = s.go_n;
endmodule // uhrp_power

//--- core/uhrp_top.sv
// uhrp_top: hid report interpreter, 64-byte reports in and out.
// assumes the usb core presents received report bytes as a stream with
// last on byte 63 and accepts transmit bytes under i_tx_ready.
// Behaviour
// - full current first, 100mA after 3s
// - low power output in fallback state
// - go output low when configured, awake
// - every report exactly 64 bytes
// - interrupt reports, 1ms, EP1, ID0
// - ids 01-3F: data, count equals id
// - ids 41-7F: data needing acknowledge
// - acknowledge is report id 40
// - old firmware: 3F and 7F refused
// - ids 80 and up are commands
// - response echoes command identifier
// - interrupt report may go unprompted
// - pin query answers selector, value
// - analog query answers 10-bit result
// - analog result msb first, ratiometric
// - selectors 10-1A name virtual pins
// - pin interrupt sends 95 and pin
`timescale 1ns/1ns
module uhrp_top
  import uhrp_pkg::*;
#(
  parameter logic [15:0] FW_REV     = 16'h0007,
  parameter longint      WAIT_CYC   = GRANT_WAIT_CYC,
  parameter longint      DETACH_LEN = DETACH_CYC
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst,
  input  wire uhrp_byte_t         i_rx,
  output logic                    o_rx_ready,
  output uhrp_byte_t              o_tx,
  input  wire logic               i_tx_ready,
  output logic                    o_data_valid,
  output logic [7:0]              o_data,
  input  wire logic               i_data_ready,
  input  wire logic               i_data_in_valid,
  input  wire logic [7:0]         i_data_in,
  output logic                    o_data_in_ready,
  input  wire logic [NUM_VIO-1:0] i_vio,
  input  wire logic [NUM_VIO-1:0] i_irq_enable,
  input  wire logic [9:0]         i_adc,
  input  wire logic               i_configured,
  input  wire logic               i_power_granted,
  input  wire logic               i_host_sleep,
  input  wire logic [9:0]         i_full_ma,
  output logic [9:0]              o_request_ma,
  output logic                    o_soft_detach,
  output logic                    o_low_power,
  output logic                    o_all_systems_go_n,
  output logic                    o_ack_pending,
  output logic                    o_persist_cmd
);
  // bind the host; framing is the usb core's job
  typedef struct packed {
    uhrp_rx_t           st;
    logic [IDX_W-1:0]   idx;
    logic [7:0]         id;
    logic [5:0]         cnt;
    logic               need_ack;
    logic [7:0]         arg;
    logic [7:0]         b0;
    logic [7:0]         b1;
    logic [7:0]         b2;
    logic [5:0]         tx_len;
    logic               rx_ready;
    uhrp_byte_t         tx;
    logic               dv;
    logic [7:0]         dq;
    logic               ack_pend;
    logic               persist;
    logic [NUM_VIO-1:0] vs1;
    logic [NUM_VIO-1:0] vs2;
    logic [NUM_VIO-1:0] vprev;
    logic [NUM_VIO-1:0] irq_pend;
    logic [9:0]         adc;
  } uhrp_state_t;

  uhrp_state_t s;
  uhrp_state_t next_s;
  logic [7:0]  id_lim;
  logic [3:0]  irq_pin;
  logic        irq_any;
  logic [7:0]  pin_val;

  // the interrupt pin number is four bits wide, and the byte index must
  // wrap exactly once per report
  if (NUM_VIO > 16 || REPORT_BYTES != (1 << IDX_W)) begin : g_bad_size
    $error("uhrp_top: report or pin sizing unsupported");
  end

  // largest legal plain data id depends on firmware revision
  assign id_lim = (FW_REV < FW_REV_FULL) ? OLD_REV_MAX : ID_DATA_MAX;

  // lowest pending interrupt pin wins
  always_comb begin
    irq_pin = '0;
    irq_any = 1'b0;
    for (int k = NUM_VIO - 1; k >= 0; k--) begin
      if (s.irq_pend[k]) begin
        irq_pin = 4'(k);
        irq_any = 1'b1;
      end
    end
  end

  // pin query value lookup
  always_comb begin
    pin_val = PIN_LOW;
    if (s.arg >= PIN_SEL_BASE && s.arg <= PIN_SEL_LAST) begin
      pin_val = s.vs2[4'(s.arg - PIN_SEL_BASE)] ? PIN_HIGH : PIN_LOW;
    end
  end

  always_comb begin
    next_s = s;
    next_s.dv = s.dv & ~i_data_ready;
    next_s.persist = 1'b0;
    // pins are asynchronous: two flops before any use
    next_s.vs1   = i_vio;
    next_s.vs2   = s.vs1;
    next_s.vprev = s.vs2;
    next_s.adc   = i_adc;
    unique case (s.st)
      RX_ID: begin
        // a new id waits until the sink has the last payload byte
        next_s.rx_ready = ~next_s.dv;
        next_s.idx = '0;
        if (i_rx.valid && s.rx_ready) begin
          next_s.id  = i_rx.data;
          next_s.idx = 6'h01;
          next_s.st  = RX_BODY;
          next_s.cnt = '0;
          next_s.need_ack = 1'b0;
          if (i_rx.data == ID_ACK) begin
            next_s.ack_pend = 1'b0;
          end else if (i_rx.data != 8'h00 && i_rx.data <= id_lim) begin
            next_s.cnt = i_rx.data[5:0];
          end else if (i_rx.data > ID_ACK && i_rx.data <= ID_ACKREQ_MAX
                       && (i_rx.data - ACK_FLAG) <= id_lim) begin
            next_s.cnt = 6'(i_rx.data - ACK_FLAG);
            next_s.need_ack = 1'b1;
          end else if (i_rx.data >= ID_CMD_MIN
                       && i_rx.data <= ID_PERSIST_MAX) begin
            next_s.persist = 1'b1;
          end
        end else if (irq_any && !s.tx.valid) begin
          // unprompted interrupt report between received reports
          next_s.rx_ready = 1'b0;
          next_s.irq_pend[irq_pin] = 1'b0;
          next_s.b0 = INTERRUPT_RSP;
          next_s.b1 = {4'h0, irq_pin};
          next_s.tx_len = 6'h02;
          next_s.idx = '0;
          next_s.st = TX_SEND;
        end
      end
      RX_BODY: begin
        // hold off when the data sink has not taken the last byte
        next_s.rx_ready = ~next_s.dv;
        if (i_rx.valid && s.rx_ready) begin
          next_s.idx = s.idx + 6'h01;
          if (s.idx <= IDX_W'(s.cnt)) begin
            next_s.dv = 1'b1;
            next_s.dq = i_rx.data;
            // one byte in flight: taking another now could overwrite it
            next_s.rx_ready = 1'b0;
          end
          if (s.idx == 6'h01) begin
            next_s.arg = i_rx.data; // byte 1 kept as the argument, payload or not
          end
          if (i_rx.last) begin
            next_s.rx_ready = 1'b0;
            next_s.idx = '0;
            next_s.st  = RX_ID;
            next_s.b0  = s.id;
            if (s.need_ack) begin
              next_s.b0 = ID_ACK;
              next_s.tx_len = 6'h00;
              next_s.st = TX_SEND;
            end else if (s.id == PIN_QUERY_CMD) begin
              next_s.st = TX_WAIT; // selector and pin_val are copied into b1, b2 next cycle, in TX_WAIT
              next_s.tx_len = 6'h02;
            end else if (s.id == ANALOG_QUERY_CMD) begin
              next_s.b1 = {6'h00, s.adc[9:8]};
              next_s.b2 = s.adc[7:0];
              next_s.tx_len = 6'h02;
              next_s.st = TX_SEND;
            end
          end
        end
      end
      TX_WAIT: begin
        next_s.b1 = s.arg;
        next_s.b2 = pin_val;
        next_s.st = TX_SEND;
      end
      TX_SEND: begin
        // sends 64 bytes: id, payload, zero padding
        if (!s.tx.valid || i_tx_ready) begin
          next_s.tx.valid = 1'b1;
          next_s.tx.last  = (s.idx == 6'h3f);
          unique case (s.idx)
            6'h00:   next_s.tx.data = s.b0;
            6'h01:   next_s.tx.data = (s.tx_len != 0) ? s.b1 : 8'h00;
            6'h02:   next_s.tx.data = (s.tx_len == 6'h02
                                       && s.b0 != INTERRUPT_RSP)
                                      ? s.b2 : 8'h00;
            default: next_s.tx.data = 8'h00;
          endcase
          next_s.idx = s.idx + 6'h01;
          if (s.idx == 6'h3f) begin
            next_s.st = RX_DRAIN;
          end
        end
      end
      RX_DRAIN: begin
        if (i_tx_ready) begin
          next_s.tx.valid = 1'b0;
          next_s.tx.last  = 1'b0;
          next_s.st = RX_ID;
        end
      end
    endcase
    // rising edge on an enabled input latches a pending interrupt; it is
    // applied after the clear so a fresh edge on the pin being sent wins
    next_s.irq_pend = next_s.irq_pend
                      | (s.vs2 & ~s.vprev & i_irq_enable);
    // outgoing data report acknowledgements not generated here; the
    // host-side sender flag is never set here; an id 40 report only clears it
    if (i_data_in_valid && !s.ack_pend) begin
      next_s.ack_pend = s.ack_pend;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s <= '0;
      s.st <= RX_ID;
    end else begin
      s <= next_s;
    end
  end

  assign o_rx_ready      = s.rx_ready;
  assign o_tx            = s.tx;
  assign o_data_valid    = s.dv;
  assign o_data          = s.dq;
  assign o_data_in_ready = 1'b0;
  assign o_ack_pending   = s.ack_pend;
  assign o_persist_cmd   = s.persist;

  uhrp_power #(
    .WAIT_CYC   (WAIT_CYC),
    .DETACH_LEN (DETACH_LEN)
  ) u_power (
    .i_sys_clk          (i_sys_clk),
    .i_rst              (i_rst),
    .i_configured       (i_configured),
    .i_power_granted    (i_power_granted),
    .i_host_sleep       (i_host_sleep),
    .i_full_ma          (i_full_ma),
    .o_request_ma       (o_request_ma),
    .o_soft_detach      (o_soft_detach),
    .o_low_power        (o_low_power),
    .o_all_systems_go_n (o_all_systems_go_n)
  );
endmodule // uhrp_top

//--- sim/uhrp_host_model.sv
// uhrp_host_model: host pc side, sends 64-byte reports, sinks replies.
// assumes the handler's report streams on the shared system clock.
`timescale 1ns/1ns
module uhrp_host_model
  import uhrp_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire uhrp_byte_t i_tx,
  input  wire logic       i_rx_ready,
  output uhrp_byte_t      o_rx,
  output logic            o_tx_ready
);
  logic       slow;      // bench sets: accept only every other cycle
  logic [7:0] rpt [64];  // last report taken
  int         nrpt;
  int         idx;
  int         rlen;
  // ids and string 4 identification precede all reports, not modelled
  initial begin
    o_rx = '0;
    o_tx_ready = 1'b1;
    slow = 1'b0;
    nrpt = 0;
    idx = 0;
  end
  // sink is open every cycle unless slow is set, since replies may come unprompted
  always @(posedge i_sys_clk) begin
    if (i_tx.valid && o_tx_ready) begin
      rpt[idx] <= i_tx.data;
      idx <= i_tx.last ? 0 : idx + 1;
      if (i_tx.last) nrpt <= nrpt + 1;
      if (i_tx.last) rlen <= idx + 1;
    end
    o_tx_ready <= #1 slow ? !o_tx_ready : 1'b1;
  end
  // whole report, id 80-8F never sent; filler is junk the device ignores
  task automatic send(input logic [7:0] id, input int n, input logic [7:0] b);
    for (int k = 0; k < REPORT_BYTES; k++) begin
      o_rx.valid = 1'b1;
      o_rx.last  = (k == REPORT_BYTES - 1);
      o_rx.data  = k == 0 ? id : k <= n ? b + 8'(k - 1) : 8'hc3;
      do @(posedge i_sys_clk); while (!i_rx_ready);
      #1;
    end
    o_rx.valid = 1'b0;
    o_rx.last  = 1'b0;
    o_rx.data  = ~o_rx.data;  // released line must not look held
  endtask
endmodule // uhrp_host_model

//--- sim/uhrp_top_monitor.sv
// uhrp_top_monitor: port assertions for the hid report handler.
// assumes it is bound into uhrp_top and shares its count parameters.
`timescale 1ns/1ns
module uhrp_top_monitor
  import uhrp_pkg::*;
#(
  parameter longint WAIT_CYC   = GRANT_WAIT_CYC,
  parameter longint DETACH_LEN = DETACH_CYC
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire uhrp_byte_t o_tx,
  input wire logic       i_tx_ready,
  input wire logic       i_configured,
  input wire logic       i_host_sleep,
  input wire logic [9:0] o_request_ma,
  input wire logic       o_soft_detach,
  input wire logic       o_low_power,
  input wire logic       o_all_systems_go_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [5:0] tx_cnt;   // byte index of the outgoing report
  longint     det_cnt;  // cycles the detach has lasted
  longint     run_cnt;  // cycles since reset went away
  // helper counters; tx index wraps to 0 after byte 63 on its own
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_cnt  <= '0;
      det_cnt <= 0;
      run_cnt <= 0;
    end else begin
      tx_cnt  <= tx_cnt + 6'(o_tx.valid && i_tx_ready);
      det_cnt <= o_soft_detach ? det_cnt + 1 : 0;
      run_cnt <= run_cnt + 1;
    end
  end
  property p_go_high; (!i_configured || i_host_sleep) |=> o_all_systems_go_n;
  endproperty
  a_go_high: assert property (p_go_high) else $error("go low while off");
  property p_low_req; o_low_power && $past(o_low_power) |->
    o_request_ma == REDUCED_MA; endproperty
  a_low_req: assert property (p_low_req) else $error("low current");
  property p_det_len; $fell(o_soft_detach) |-> det_cnt == DETACH_LEN;
  endproperty
  a_det_len: assert property (p_det_len) else $error("detach length");
  property p_det_wait; $rose(o_soft_detach) |->
    run_cnt >= WAIT_CYC - 1 && run_cnt <= WAIT_CYC + 3; endproperty
  a_det_wait: assert property (p_det_wait) else $error("grant wait");
  property p_tx_hold; o_tx.valid && !i_tx_ready |=>
    o_tx.valid && $stable(o_tx); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  property p_tx_last; o_tx.valid && i_tx_ready |->
    o_tx.last == (tx_cnt == 6'd63); endproperty
  a_tx_last: assert property (p_tx_last) else $error("report length");
  property p_first_id; o_tx.valid && tx_cnt == 6'd0 |->
    o_tx.data == ID_ACK || o_tx.data >= ID_CMD_MIN; endproperty
  a_first_id: assert property (p_first_id) else $error("reply id");
  property p_pad; o_tx.valid && tx_cnt > 6'd2 |-> o_tx.data == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("nonzero filler");
endmodule // uhrp_top_monitor

bind uhrp_top uhrp_top_monitor #(
  .WAIT_CYC(WAIT_CYC), .DETACH_LEN(DETACH_LEN)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_tx(o_tx), .i_tx_ready(i_tx_ready),
  .i_configured(i_configured), .i_host_sleep(i_host_sleep),
  .o_request_ma(o_request_ma), .o_soft_detach(o_soft_detach),
  .o_low_power(o_low_power), .o_all_systems_go_n(o_all_systems_go_n));

//--- sim/uhrp_top_test.sv
// uhrp_top_test: self-checking bench for the hid report handler.
// assumes the host model on the report streams and short power counts.
`timescale 1ns/1ns
module uhrp_top_test
  import uhrp_pkg::*;
;
  localparam longint WAIT = 100;
  localparam longint DET  = 4;
  logic        clk, rst, tx_rdy, rx_rdy, dv, drdy, cfg, gnt, slp;
  logic        det, lowp, go_n;
  uhrp_byte_t  rx, tx;
  logic [7:0]  data;
  logic [7:0]  got [$];
  logic [10:0] vio, irq_en;
  logic [9:0]  adc, full_ma, req_ma;
  int          num_errors, samples_checked;

  uhrp_top #(.WAIT_CYC(WAIT), .DETACH_LEN(DET)) u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_rx(rx), .o_rx_ready(rx_rdy),
    .o_tx(tx), .i_tx_ready(tx_rdy), .o_data_valid(dv), .o_data(data),
    .i_data_ready(drdy), .i_data_in_valid(1'b0), .i_data_in(8'h00),
    .o_data_in_ready(), .i_vio(vio), .i_irq_enable(irq_en), .i_adc(adc),
    .i_configured(cfg), .i_power_granted(gnt), .i_host_sleep(slp),
    .i_full_ma(full_ma), .o_request_ma(req_ma), .o_soft_detach(det),
    .o_low_power(lowp), .o_all_systems_go_n(go_n), .o_ack_pending(),
    .o_persist_cmd());
  uhrp_host_model u_host (.i_sys_clk(clk), .i_tx(tx), .i_rx_ready(rx_rdy),
    .o_rx(rx), .o_tx_ready(tx_rdy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // data sink stalls every other cycle so the handler must hold bytes
  always @(posedge clk) begin
    if (dv && drdy) got.push_back(data);
    drdy <= #1 ~drdy;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    cyc(2);
  endtask
  task automatic wait_rpt(input int n);
    for (int k = 0; k < 400 && u_host.nrpt < n; k++) cyc(1);
    check("report count", 16'(u_host.nrpt), 16'(n));
  endtask
  task automatic expect_data(input int n, input logic [7:0] b);
    for (int k = 0; k < 300 && got.size() < n; k++) cyc(1);
    cyc(10);
    check("data count", 16'(got.size()), 16'(n));
    foreach (got[k]) check("data byte", got[k], b + 8'(k));
    got.delete();
  endtask
  task automatic t_fallback();
    gnt = 1'b0;
    do_reset();
    check("request full", req_ma, full_ma);
    cyc(int'(WAIT) - 10);
    check("low early", lowp, 1'b0);
    cyc(40);
    check("low power", lowp, 1'b1);
    check("request low", req_ma, REDUCED_MA);
  endtask
  task automatic t_grant();
    gnt = 1'b1;
    do_reset();
    cyc(int'(WAIT) + 50);
    check("grant low", lowp, 1'b0);
    check("grant req", req_ma, full_ma);
    check("go on", go_n, 1'b0);
    slp = 1'b1;
    cyc(3);
    check("go asleep", go_n, 1'b1);
    slp = 1'b0;
    cfg = 1'b0;
    cyc(3);
    check("go unconfigured", go_n, 1'b1);
    cfg = 1'b1;
    cyc(3);
  endtask
  task automatic t_data();
    int n0;
    n0 = u_host.nrpt;
    u_host.send(8'h03, 3, 8'h20);
    expect_data(3, 8'h20);
    u_host.send(ID_DATA_MAX, 63, 8'h01);
    expect_data(63, 8'h01);
    check("no reply", 16'(u_host.nrpt), 16'(n0));
  endtask
  // ack-requesting data report: payload delivered, then a 64-byte acknowledge comes back
  task automatic t_ack();
    int n0;
    n0 = u_host.nrpt;
    u_host.slow = 1'b1;
    u_host.send(8'h42, 2, 8'h50);
    expect_data(2, 8'h50);
    wait_rpt(n0 + 1);
    check("ack id", u_host.rpt[0], ID_ACK);
    check("ack length", 16'(u_host.rlen), 16'd64);
    check("ack filler", u_host.rpt[63], 8'h00);
    u_host.slow = 1'b0;
  endtask
  task automatic t_pin();
    int n0;
    logic [7:0] s;
    vio = 11'h5a5;
    cyc(4);
    for (int k = 0; k < NUM_VIO; k++) begin
      n0 = u_host.nrpt;
      s = PIN_SEL_BASE + 8'(k);
      u_host.send(PIN_QUERY_CMD, 1, s);
      wait_rpt(n0 + 1);
      check("pin id", u_host.rpt[0], PIN_QUERY_CMD);
      check("pin sel", u_host.rpt[1], s);
      check("pin val", u_host.rpt[2], vio[k] ? PIN_HIGH : PIN_LOW);
    end
    check("no data", 16'(got.size()), 16'd0);
  endtask
  task automatic t_analog();
    int n0;
    logic [9:0] v [2] = '{10'h236, 10'h3ff};
    foreach (v[k]) begin
      n0 = u_host.nrpt;
      adc = v[k];
      cyc(2);
      u_host.send(ANALOG_QUERY_CMD, 0, 8'h00);
      wait_rpt(n0 + 1);
      check("adc id", u_host.rpt[0], ANALOG_QUERY_CMD);
      check("adc msb", u_host.rpt[1], 8'(v[k] >> 8));
      check("adc lsb", u_host.rpt[2], v[k][7:0]);
    end
  endtask
  task automatic t_irq();
    int n0;
    vio = 11'h000;
    irq_en = 11'h200;
    cyc(6);
    n0 = u_host.nrpt;
    vio = 11'h200;
    wait_rpt(n0 + 1);
    check("irq id", u_host.rpt[0], INTERRUPT_RSP);
    check("irq pin", u_host.rpt[1], 8'h09);
    check("irq filler", u_host.rpt[2], 8'h00);
    irq_en = 11'h000;
  endtask
  initial begin
    {rst, drdy, cfg, gnt, slp} = 5'b1_0100;
    {vio, irq_en} = '0;
    adc = 10'h000;
    full_ma = 10'h1f4;
    #1;
    t_fallback();
    t_grant();
    t_data();
    t_ack();
    t_pin();
    t_analog();
    t_irq();
    summarize();
  end
  // watchdog: the whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule // uhrp_top_test
